// ==== include/urs_pkg.sv ====
// shared constants, register map and decode helpers of the receive
// sampling and buffer status block
// assumes a 32-bit classic wishbone bus with byte registers in the low lane
package urs_pkg;

    // register word indices, byte address is four times the index
    localparam logic [5:0] IDX_OVR  = 6'h00;
    localparam logic [5:0] IDX_MODE = 6'h01;
    localparam logic [5:0] IDX_SPOS = 6'h02;
    localparam logic [5:0] IDX_STAT = 6'h03;
    localparam logic [5:0] IDX_TBUF = 6'h04;
    localparam logic [5:0] IDX_RBUF = 6'h05;
    localparam logic [5:0] IDX_ISR  = 6'h06;
    localparam logic [5:0] IDX_IMR  = 6'h07;

    // field positions
    localparam int MODE_SEL_BIT = 0;
    localparam int STAT_TBE_BIT = 0;
    localparam int STAT_RBF_BIT = 1;
    localparam int STAT_DCT_BIT = 2;

    // reset values
    localparam logic [3:0] RST_OVR  = 4'h0;
    localparam logic       RST_MODE = 1'h0;
    localparam logic [3:0] RST_SPOS = 4'h6;
    localparam logic [2:0] RST_IMR  = 3'h0;
    localparam logic       RST_TBE  = 1'h1;

    // oversample rate decode
    localparam logic [3:0] OVS_LOW_CODE = 4'h7;
    localparam logic [4:0] OVS_DEFAULT  = 5'h10;
    localparam logic [4:0] SAMPLE_SPAN  = 5'h2;
    localparam logic [4:0] AUTO_OFFSET  = 5'h2;

    // clocks per bit from the oversample code
    function automatic logic [4:0] rate_of(input logic [3:0] code);
        rate_of = (code < OVS_LOW_CODE) ? OVS_DEFAULT : {1'b0, code};
    endfunction

    // automatic first sample period for a rate
    function automatic logic [3:0] auto_start(input logic [4:0] rate);
        logic [4:0] s;
        s = (rate >> 1) - AUTO_OFFSET;
        auto_start = s[3:0];
    endfunction

    // two of three vote
    function automatic logic vote3(input logic a,
                                   input logic b,
                                   input logic c);
        vote3 = (a & b) | (a & c) | (b & c);
    endfunction

endpackage

// ==== include/urs_samp_if.sv ====
// carrier between the register side and the bit sampler
// assumes both ends run on the one system clock
interface urs_samp_if;
    logic       os_tick;
    logic       rx_line;
    logic       rx_sync;
    logic [4:0] rate;
    logic [3:0] start;
    logic       bit_valid;
    logic       bit_value;

    modport ctl (output os_tick, rx_line, rx_sync, rate, start,
                 input  bit_valid, bit_value);
    modport smp (input  os_tick, rx_line, rx_sync, rate, start,
                 output bit_valid, bit_value);
endinterface

// ==== src/urs_bit_sampler.sv ====
// oversample counter and three-sample majority vote for received bits
// assumes os_tick is a one-cycle enable and rx_sync marks a bit boundary
module urs_bit_sampler
    import urs_pkg::*;
(
    // system
    input  wire logic clk_i,
    input  wire logic rst_i,
    // sampling controls and results
    urs_samp_if.smp   sif
);

    typedef struct packed {
        logic [4:0] cnt;
        logic [1:0] smp;
        logic       valid;
        logic       value;
    } urs_smp_st_t;

    urs_smp_st_t st;
    urs_smp_st_t next_st;
    logic [4:0]  first;
    logic [4:0]  last;

    assign first = {1'b0, sif.start};
    assign last  = first + SAMPLE_SPAN;

    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        if (sif.os_tick) begin
            if (sif.rx_sync) begin
                next_st.cnt = 5'h00;
            end else begin
                if (st.cnt == first) begin
                    next_st.smp[0] = sif.rx_line;
                end
                if (st.cnt == first + 5'h01) begin
                    next_st.smp[1] = sif.rx_line;
                end
                if (st.cnt == last) begin
                    next_st.valid = 1'b1;
                    next_st.value = vote3(st.smp[0], st.smp[1],
                                          sif.rx_line);
                end
                if (st.cnt >= sif.rate - 5'h01) begin
                    next_st.cnt = 5'h00;
                end else begin
                    next_st.cnt = st.cnt + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sif.bit_valid = st.valid;
    assign sif.bit_value = st.value;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence third_sample_s;
        sif.os_tick && !sif.rx_sync && st.cnt == last;
    endsequence

    a_vote_result: assert property (third_sample_s |=>
        st.valid && st.value == vote3($past(st.smp[0]), $past(st.smp[1]),
                                      $past(sif.rx_line)))
        else $error("majority vote result wrong");
    a_valid_position: assert property (st.valid |->
        $past(st.cnt) == $past(last))
        else $error("bit resolved at wrong period");
    a_count_wrap: assert property (
        sif.os_tick && !sif.rx_sync && st.cnt == sif.rate - 5'h01
        |=> st.cnt == 5'h00)
        else $error("period count did not restart");

endmodule

// ==== src/urs_uart_rx_status.sv ====
// receive sample-position control and buffer / flow status registers
// assumes a classic wishbone master, one system clock, and that the
// transmit shifter, frame logic and baud generator sit outside
//
// Operation
// - tx empty flag sets when the shifter takes the byte; writes clear it.
// - a done frame fills the rx holding byte, sets full; a read clears it.
// - the delta flag shows a cts level change since the last status read.
// - codes 0 to 6 give 16 clocks per bit and codes 7 to 15 give 7 to 15.
// - mode 0 picks the start period itself, mode 1 takes the position field.
// - the mode byte holds the mode select in bit 0; upper bits read zero.
// - the position byte holds the start period in bits 3:0, used in mode 1.
// - the position register resets to 06h.
// - each bit is sampled three times from the start period, counted from 0.
// - auto mode takes three periods in a row, from 1 at rate 7 to 6 at 16.
// - a programmed start replaces the automatic one; sampling begins there.
module urs_uart_rx_status
    import urs_pkg::*;
(
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o,
    // transmit side
    input  wire logic        tx_take_i,
    output      logic [7:0]  tx_data_o,
    output      logic        tx_holding_empty_o,
    // receive side
    input  wire logic        os_tick_i,
    input  wire logic        rx_line_i,
    input  wire logic        rx_sync_i,
    input  wire logic        rx_frame_done_i,
    input  wire logic [7:0]  rx_shift_data_i,
    output      logic        rx_bit_valid_o,
    output      logic        rx_bit_value_o,
    output      logic        rx_holding_full_o,
    // flow control
    input  wire logic        cts_n_i,
    // interrupt
    output      logic        irq_o
);

    typedef struct packed {
        logic [3:0]  ovr;
        logic        mode;
        logic [3:0]  spos;
        logic [7:0]  tbuf;
        logic        tbe;
        logic [7:0]  rbuf;
        logic        rbf;
        logic        dcts;
        logic        cts_last;
        logic        cts_seen;
        logic [2:0]  isr;
        logic [2:0]  imr;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
    } urs_top_st_t;

    urs_top_st_t st;
    urs_top_st_t next_st;
    logic [5:0]  idx;
    logic        req;
    logic        wr;
    logic        rd;
    logic        tbe_set;
    logic        cts_chg;
    logic [2:0]  events;
    logic [4:0]  rate;

    urs_samp_if sif ();

    urs_bit_sampler u_sampler (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sif   (sif)
    );

    // sampling setup handed to the sampler
    assign rate        = rate_of(st.ovr);
    assign sif.rate    = rate;
    assign sif.start   = st.mode ? st.spos
                                 : auto_start(rate);
    assign sif.os_tick = os_tick_i;
    assign sif.rx_line = rx_line_i;
    assign sif.rx_sync = rx_sync_i;

    // bus request and flag event decode
    assign idx     = wb_adr_i[7:2];
    assign req     = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wr      = req & wb_we_i & wb_sel_i[0];
    assign rd      = req & ~wb_we_i;
    assign tbe_set = tx_take_i & ~st.tbe;
    assign cts_chg = st.cts_seen & (cts_n_i != st.cts_last);
    assign events  = {cts_chg, rx_frame_done_i, tbe_set};

    always_comb begin
        next_st          = st;
        next_st.ack      = req;
        next_st.dat      = 32'h0000_0000;
        next_st.cts_last = cts_n_i;
        next_st.cts_seen = 1'b1;
        if (rd) begin
            case (idx)
                IDX_OVR:  next_st.dat[3:0] = st.ovr;
                IDX_MODE: next_st.dat[MODE_SEL_BIT] = st.mode;
                IDX_SPOS: next_st.dat[3:0] = st.spos;
                IDX_STAT: begin
                    next_st.dat[STAT_TBE_BIT] = st.tbe;
                    next_st.dat[STAT_RBF_BIT] = st.rbf;
                    next_st.dat[STAT_DCT_BIT] = st.dcts;
                    next_st.dcts              = 1'b0;
                end
                IDX_TBUF: next_st.dat[7:0] = st.tbuf;
                IDX_RBUF: begin
                    next_st.dat[7:0] = st.rbuf;
                    next_st.rbf      = 1'b0;
                end
                IDX_ISR:  next_st.dat[2:0] = st.isr;
                IDX_IMR:  next_st.dat[2:0] = st.imr;
                default:  next_st.dat = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (idx)
                IDX_OVR:  next_st.ovr  = wb_dat_i[3:0];
                IDX_MODE: next_st.mode = wb_dat_i[MODE_SEL_BIT];
                IDX_SPOS: next_st.spos = wb_dat_i[3:0];
                IDX_TBUF: begin
                    next_st.tbuf = wb_dat_i[7:0];
                    next_st.tbe  = 1'b0;
                end
                IDX_ISR:  next_st.isr = st.isr & ~wb_dat_i[2:0];
                IDX_IMR:  next_st.imr = wb_dat_i[2:0];
                default:  next_st.ovr = st.ovr;
            endcase
        end
        // hardware sets win over software clears
        if (tbe_set) begin
            next_st.tbe = 1'b1;
        end
        if (rx_frame_done_i) begin
            next_st.rbuf = rx_shift_data_i;
            next_st.rbf  = 1'b1;
        end
        if (cts_chg) begin
            next_st.dcts = 1'b1;
        end
        next_st.isr = next_st.isr | events;
        next_st.irq = |(next_st.isr & next_st.imr);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st      <= '0;
            st.ovr  <= RST_OVR;
            st.mode <= RST_MODE;
            st.spos <= RST_SPOS;
            st.tbe  <= RST_TBE;
            st.imr  <= RST_IMR;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign wb_dat_o           = st.dat;
    assign wb_ack_o           = st.ack;
    assign tx_data_o          = st.tbuf;
    assign tx_holding_empty_o = st.tbe;
    assign rx_holding_full_o  = st.rbf;
    assign rx_bit_valid_o     = sif.bit_valid;
    assign rx_bit_value_o     = sif.bit_value;
    assign irq_o              = st.irq;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence tbuf_write_s;
        wr && idx == IDX_TBUF && !tbe_set;
    endsequence

    sequence rbuf_read_s;
        rd && idx == IDX_RBUF && !rx_frame_done_i;
    endsequence

    sequence cts_edge_s;
        st.cts_seen && cts_n_i != st.cts_last;
    endsequence

    a_tbe_write_clear: assert property (tbuf_write_s |=>
        !st.tbe && st.tbuf == $past(wb_dat_i[7:0]))
        else $error("holding write did not clear empty flag");
    a_tbe_take_set: assert property (tx_take_i |=> st.tbe)
        else $error("take did not set empty flag");
    a_rbf_frame_set: assert property (rx_frame_done_i |=>
        st.rbf && st.rbuf == $past(rx_shift_data_i))
        else $error("frame not copied to receive holding");
    a_rbf_read_clear: assert property (rbuf_read_s |=> !st.rbf)
        else $error("holding read did not clear full flag");
    a_dcts_change: assert property (cts_edge_s |=> st.dcts [*2]
        or (st.dcts ##1 $past(rd && idx == IDX_STAT)))
        else $error("flow input change not flagged");
    a_dcts_quiet: assert property (
        !st.dcts && !cts_chg |=> !st.dcts)
        else $error("delta flag set with no change");
    a_spos_reset: assert property ($past(rst_i) |->
        st.spos == RST_SPOS)
        else $error("position not 06h after reset");
    a_mode_read: assert property (rd && idx == IDX_MODE |=>
        wb_ack_o && wb_dat_o == {31'h0, $past(st.mode)})
        else $error("mode register read wrong");
    a_auto_start: assert property (!st.mode |->
        sif.start == auto_start(rate) && sif.start <= 4'h6)
        else $error("automatic start period wrong");
    a_prog_start: assert property (st.mode |-> sif.start == st.spos)
        else $error("programmed start not applied");
    a_irq_level: assert property (irq_o == |(st.isr & st.imr))
        else $error("interrupt level does not follow status");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    sequence bus_take_s;
        wb_cyc_i && wb_stb_i && !st.ack;
    endsequence

    sequence stat_read_s;
        rd && idx == IDX_STAT;
    endsequence

    sequence isr_write_s;
        wr && idx == IDX_ISR;
    endsequence

    a_ack_next: assert property (bus_take_s |=>
        wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_dat_idle: assert property (!wb_ack_o |->
        wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_unmapped_read: assert property (rd && idx > IDX_IMR |=>
        wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ovr_read: assert property (rd && idx == IDX_OVR |=>
        wb_dat_o == {28'h0, $past(st.ovr)})
        else $error("oversample register read wrong");
    a_spos_read: assert property (rd && idx == IDX_SPOS |=>
        wb_dat_o == {28'h0, $past(st.spos)})
        else $error("position register read wrong");
    a_stat_read: assert property (stat_read_s |=>
        wb_dat_o == {29'h0, $past(st.dcts), $past(st.rbf), $past(st.tbe)})
        else $error("status read wrong");
    a_rbuf_read: assert property (rd && idx == IDX_RBUF |=>
        wb_dat_o == {24'h0, $past(st.rbuf)})
        else $error("receive holding read wrong");
    a_dcts_clear: assert property (stat_read_s ##0 !cts_chg |=>
        !st.dcts)
        else $error("status read did not clear delta flag");
    a_dcts_set: assert property (cts_chg |=>
        st.dcts)
        else $error("delta flag lost on change");
    a_rbf_hold: assert property (st.rbf && !(rd && idx == IDX_RBUF) |=>
        st.rbf)
        else $error("full flag dropped with no read");
    a_rbf_quiet: assert property (!st.rbf && !rx_frame_done_i |=>
        !st.rbf)
        else $error("full flag set with no frame");
    a_tbe_hold: assert property (st.tbe && !(wr && idx == IDX_TBUF) |=>
        st.tbe)
        else $error("empty flag dropped with no write");
    a_tbe_quiet: assert property (!st.tbe && !tx_take_i |=>
        !st.tbe)
        else $error("empty flag set with no take");
    a_ovr_write: assert property (wr && idx == IDX_OVR |=>
        st.ovr == $past(wb_dat_i[3:0]))
        else $error("oversample write not stored");
    a_mode_write: assert property (wr && idx == IDX_MODE |=>
        st.mode == $past(wb_dat_i[MODE_SEL_BIT]))
        else $error("mode write not stored");
    a_spos_write: assert property (wr && idx == IDX_SPOS |=>
        st.spos == $past(wb_dat_i[3:0]))
        else $error("position write not stored");
    a_rate_low: assert property (st.ovr <= 4'h6 |->
        rate == 5'h10)
        else $error("low codes not at 16 clocks per bit");
    a_rate_high: assert property (st.ovr >= 4'h7 |->
        rate == {1'b0, st.ovr})
        else $error("high code rate wrong");
    a_auto_low: assert property (!st.mode && rate == 5'h07 |->
        sif.start == 4'h1)
        else $error("automatic start wrong at lowest rate");
    a_auto_high: assert property (!st.mode && rate == 5'h10 |->
        sif.start == 4'h6)
        else $error("automatic start wrong at highest rate");
    a_isr_clear: assert property (isr_write_s ##0 (events == 3'h0) |=>
        st.isr == ($past(st.isr) & ~$past(wb_dat_i[2:0])))
        else $error("interrupt status clear wrong");
    a_isr_event: assert property (|events |=>
        (st.isr & $past(events)) == $past(events))
        else $error("event not latched in interrupt status");
    a_reset_out: assert property ($past(rst_i) |->
        !wb_ack_o && tx_holding_empty_o && !rx_holding_full_o && !irq_o)
        else $error("outputs wrong after reset");

endmodule

// ==== verification/urs_line_model.sv ====
// remote serial port model: sends one bit per go pulse as oversample ticks
// assumes one system clock; ticks stand still between bits, line idles high
module urs_line_model (
    // control
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [4:0]  rate_i,
    input  wire logic [15:0] pat_i,
    // line side
    output      logic        os_tick_o,
    output      logic        rx_sync_o,
    output      logic        rx_line_o,
    output      logic        busy_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        os_tick_o = 1'b0;
        rx_sync_o = 1'b0;
        rx_line_o = 1'b1;
        busy_o    = 1'b0;
    end

    // bit boundary tick, then one tick per period with its line level
    always begin
        @(posedge clk_i);
        if (go_i) begin
            busy_o    <= 1'b1;
            os_tick_o <= 1'b1;
            rx_sync_o <= 1'b1;
            @(posedge clk_i);
            os_tick_o <= 1'b0;
            rx_sync_o <= 1'b0;
            for (int p = 0; p < int'(rate_i); p++) begin
                @(posedge clk_i);
                rx_line_o <= pat_i[p];
                os_tick_o <= 1'b1;
                @(posedge clk_i);
                os_tick_o <= 1'b0;
            end
            @(posedge clk_i);
            rx_line_o <= 1'b1;
            busy_o    <= 1'b0;
        end
    end
endmodule

// ==== verification/urs_tb_top.sv ====
// self-checking bench of the receive sampling and buffer status block
// assumes urs_line_model on the line and byte registers on wishbone
module uart_rx_sampling_status_tb_top
    import urs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_q;
    logic        wb_ack;
    logic        tx_take = 1'b0;
    logic [7:0]  tx_data;
    logic        tbe;
    logic        os_tick;
    logic        rx_line;
    logic        rx_sync;
    logic        frame_done = 1'b0;
    logic [7:0]  shift_data = 8'h00;
    logic        bit_valid;
    logic        bit_value;
    logic        rbf;
    logic        cts_n = 1'b1;
    logic        irq;
    logic        go = 1'b0;
    logic [4:0]  rate = 5'h10;
    logic [15:0] pat = 16'h0;
    logic        busy;
    int          errors = 0;
    int          checks = 0;

    always #5 clk_i = ~clk_i;

    urs_uart_rx_status dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
        .tx_take_i(tx_take), .tx_data_o(tx_data), .tx_holding_empty_o(tbe),
        .os_tick_i(os_tick), .rx_line_i(rx_line), .rx_sync_i(rx_sync),
        .rx_frame_done_i(frame_done), .rx_shift_data_i(shift_data),
        .rx_bit_valid_o(bit_valid), .rx_bit_value_o(bit_value),
        .rx_holding_full_o(rbf), .cts_n_i(cts_n), .irq_o(irq));

    urs_line_model line_u (
        .clk_i(clk_i), .go_i(go), .rate_i(rate), .pat_i(pat),
        .os_tick_o(os_tick), .rx_sync_o(rx_sync), .rx_line_o(rx_line),
        .busy_o(busy));

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [5:0] idx,
                           input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        q = wb_q[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        wb_xfer(1'b0, idx, 8'h00, q);
        chk({24'h0, q}, {24'h0, exp});
    endtask

    task automatic pulse_edges(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one bit whose three samples at s..s+2 vote to v, all others to ~v
    task automatic send_bit(input logic [4:0] r, input logic [3:0] s,
                            input logic v);
        int n;
        int pulses;
        n = 0;
        pulses = 0;
        rate <= r;
        pat  <= v ? (16'h0005 << s) : ~(16'h0005 << s);
        go   <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
            if (bit_valid === 1'b1) pulses++;
        end while (busy !== 1'b0 && n < 80);
        if (n >= 80) begin
            errors++;
            report_and_stop();
        end
        chk(32'(pulses), 32'h1);
        chk({31'h0, bit_value}, {31'h0, v});
    endtask

    task automatic t_regs();
        rd_chk(IDX_OVR, 8'h00);
        rd_chk(IDX_MODE, 8'h00);
        rd_chk(IDX_SPOS, 8'h06);
        rd_chk(IDX_STAT, 8'h01);
        wr(IDX_MODE, 8'hFF);
        rd_chk(IDX_MODE, 8'h01);
        wr(IDX_SPOS, 8'hFF);
        rd_chk(IDX_SPOS, 8'h0F);
        wr(IDX_OVR, 8'hFF);
        rd_chk(IDX_OVR, 8'h0F);
        wr(6'h20, 8'h55);
        rd_chk(6'h20, 8'h00);
        wr(IDX_MODE, 8'h00);
        wr(IDX_SPOS, 8'h06);
    endtask

    task automatic t_tx();
        wr(IDX_IMR, 8'h01);
        wr(IDX_TBUF, 8'h5A);
        chk({24'h0, tx_data}, 32'h5A);
        rd_chk(IDX_STAT, 8'h00);
        chk({31'h0, irq}, 32'h0);
        tx_take <= 1'b1;
        @(posedge clk_i);
        tx_take <= 1'b0;
        pulse_edges(2);
        chk({31'h0, tbe}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_IMR, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_ISR, 8'h07);
        wr(IDX_IMR, 8'h01);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_rx();
        shift_data <= 8'hA5;
        frame_done <= 1'b1;
        @(posedge clk_i);
        frame_done <= 1'b0;
        shift_data <= 8'h3C;
        pulse_edges(2);
        chk({31'h0, rbf}, 32'h1);
        rd_chk(IDX_STAT, 8'h03);
        rd_chk(IDX_RBUF, 8'hA5);
        rd_chk(IDX_STAT, 8'h01);
    endtask

    task automatic t_cts();
        cts_n <= 1'b0;
        pulse_edges(2);
        rd_chk(IDX_STAT, 8'h05);
        rd_chk(IDX_STAT, 8'h01);
    endtask

    task automatic t_auto();
        logic [4:0] r;
        for (int c = 0; c < 16; c++) begin
            r = (c < 7) ? 5'h10 : 5'(c);
            wr(IDX_OVR, 8'(c));
            rd_chk(IDX_OVR, 8'(c));
            send_bit(r, 4'(r / 2 - 2), 1'b1);
            send_bit(r, 4'(r / 2 - 2), 1'b0);
        end
    endtask

    task automatic t_prog();
        wr(IDX_MODE, 8'h01);
        wr(IDX_OVR, 8'h00);
        wr(IDX_SPOS, 8'h00);
        send_bit(5'h10, 4'h0, 1'b1);
        wr(IDX_SPOS, 8'h0D);
        send_bit(5'h10, 4'hD, 1'b0);
        wr(IDX_OVR, 8'h07);
        wr(IDX_SPOS, 8'h04);
        send_bit(5'h07, 4'h4, 1'b1);
        wr(IDX_MODE, 8'h00);
        send_bit(5'h07, 4'h1, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_tx();
        t_rx();
        t_cts();
        t_auto();
        t_prog();
        report_and_stop();
    end
endmodule
